/* tpu_drive_model.sv */
// Far side: a quadrature encoder and a power stage counting overlap.
// Assumes the bench asks for one encoder step per cycle of step_in.
`timescale 1ns/10ps
module tpu_drive_model (
	// Clock and encoder control
	input  wire logic clk_sys_in,
	input  wire logic step_in,
	input  wire logic fwd_in,
	// Power stage gates
	input  wire logic pwm_in,
	input  wire logic pwm_n_in,
	// Phases and overlap count
	output logic      phase_a_out,
	output logic      phase_b_out,
	output int        overlap_out
);
	logic [1:0] pos_ff = 2'h0;
	initial overlap_out = 0;
	// Gray order 00, 10, 11, 01 makes phase A lead when going forward.
	assign phase_a_out = pos_ff[0] ^ pos_ff[1];
	assign phase_b_out = pos_ff[1];
	always @(posedge clk_sys_in) begin
		if (step_in)
			pos_ff <= fwd_in ? pos_ff + 2'h1 : pos_ff - 2'h1;
		if (pwm_in && pwm_n_in)
			overlap_out <= overlap_out + 1;
	end
endmodule : tpu_drive_model

/* tpu_event_detect.sv */
// Event input detector: rising, falling, both edges or level.
// Assumes the selected trigger input is synchronous to clk_sys_in.
`timescale 1ns/10ps
module tpu_event_detect (
	// Clock and reset
	input  wire logic                   clk_sys_in,
	input  wire logic                   resetn_in,
	// Trigger
	input  wire logic                   trig_in,
	input  wire tpu_pkg::tpu_edge_t     edge_sel_in,
	output logic                        event_out
);
	typedef struct packed {
		logic prev;
	} tpu_ed_state_t;

	tpu_ed_state_t state_ff;
	tpu_ed_state_t nxt_state;

	always_comb begin
		nxt_state.prev = trig_in;
	end

	always_ff @(posedge clk_sys_in) begin
		if (!resetn_in) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	always_comb begin
		unique case (edge_sel_in)
			tpu_pkg::TPU_EDGE_RISE:  event_out = trig_in & ~state_ff.prev;
			tpu_pkg::TPU_EDGE_FALL:  event_out = ~trig_in & state_ff.prev;
			tpu_pkg::TPU_EDGE_BOTH:  event_out = trig_in ^ state_ff.prev;
			tpu_pkg::TPU_EDGE_LEVEL: event_out = trig_in;
		endcase
	end
endmodule : tpu_event_detect

/* tpu_pkg.sv */
// Shared constants and mode encodings for the timer/counter/PWM unit.
// Assumes all users refer to names with the package scope.
package tpu_pkg;
	// ****************************************
	// Modes and encodings
	// ****************************************
	typedef enum logic [2:0] {
		TPU_MODE_CMP   = 3'h0,
		TPU_MODE_CAP   = 3'h1,
		TPU_MODE_QUAD  = 3'h2,
		TPU_MODE_PWM   = 3'h3,
		TPU_MODE_PRPWM = 3'h4,
		TPU_MODE_PWMDT = 3'h5
	} tpu_mode_t;

	typedef enum logic [1:0] {
		TPU_DIR_UP   = 2'h0,
		TPU_DIR_DOWN = 2'h1,
		TPU_DIR_UPDN = 2'h2
	} tpu_dir_t;

	typedef enum logic [1:0] {
		TPU_EDGE_RISE  = 2'h0,
		TPU_EDGE_FALL  = 2'h1,
		TPU_EDGE_BOTH  = 2'h2,
		TPU_EDGE_LEVEL = 2'h3
	} tpu_edge_t;

	// ****************************************
	// Sizes and reset values
	// ****************************************
	localparam int TPU_WIDTH_WIDE   = 32;
	localparam int TPU_WIDTH_NARROW = 16;
	localparam int TPU_NUM_EVENTS   = 5;
	localparam int TPU_EV_START     = 0;
	localparam int TPU_EV_RELOAD    = 1;
	localparam int TPU_EV_STOP      = 2;
	localparam int TPU_EV_COUNT     = 3;
	localparam int TPU_EV_CAPTURE   = 4;
	localparam int TPU_MAX_PRESCALE = 7;
	localparam int TPU_DT_WIDTH     = 8;
	localparam logic [31:0] TPU_LFSR_SEED = 32'hACE1_0001;
endpackage : tpu_pkg

/* tpu_timer_pwm_unit.sv */
// Timer/counter/PWM unit with selectable modes, events and kill.
// Assumes trigger and phase inputs are synchronous to clk_sys_in.
`timescale 1ns/10ps
module tpu_timer_pwm_unit #(
	parameter int WIDTH   = tpu_pkg::TPU_WIDTH_WIDE,
	parameter int NUM_SRC = 8
) (
	// Clock and reset
	input  wire logic                       clk_sys_in,
	input  wire logic                       resetn_in,
	// Configuration
	input  wire logic                       enable_in,
	input  wire tpu_pkg::tpu_mode_t         mode_in,
	input  wire tpu_pkg::tpu_dir_t          dir_in,
	input  wire logic [2:0]                 prescale_in,
	input  wire logic [tpu_pkg::TPU_DT_WIDTH-1:0] dead_time_in,
	input  wire logic                       kill_level_in,
	// Shadow value writes
	input  wire logic [WIDTH-1:0]           period_buf_in,
	input  wire logic                       period_wr_in,
	input  wire logic [WIDTH-1:0]           compare_buf_in,
	input  wire logic                       compare_wr_in,
	// Trigger sources and selection
	input  wire logic [NUM_SRC-1:0]         trig_src_in,
	input  wire logic [$clog2(NUM_SRC)-1:0] start_sel_in,
	input  wire logic [$clog2(NUM_SRC)-1:0] reload_sel_in,
	input  wire logic [$clog2(NUM_SRC)-1:0] stop_sel_in,
	input  wire logic [$clog2(NUM_SRC)-1:0] count_sel_in,
	input  wire logic [$clog2(NUM_SRC)-1:0] capture_sel_in,
	input  wire tpu_pkg::tpu_edge_t         start_edge_in,
	input  wire tpu_pkg::tpu_edge_t         reload_edge_in,
	input  wire tpu_pkg::tpu_edge_t         stop_edge_in,
	input  wire tpu_pkg::tpu_edge_t         count_edge_in,
	input  wire tpu_pkg::tpu_edge_t         capture_edge_in,
	// Kill and quadrature phases
	input  wire logic                       kill_in,
	input  wire logic                       phase_a_in,
	input  wire logic                       phase_b_in,
	// Status and outputs
	output logic [WIDTH-1:0]                count_out,
	output logic [WIDTH-1:0]                capture_out,
	output logic                            running_out,
	output logic                            underflow_out,
	output logic                            overflow_out,
	output logic                            cc_event_out,
	output logic                            irq_tc_out,
	output logic                            irq_cc_out,
	output logic                            pwm_out,
	output logic                            pwm_n_out
);
	if (WIDTH != tpu_pkg::TPU_WIDTH_WIDE &&
	    WIDTH != tpu_pkg::TPU_WIDTH_NARROW) begin : g_bad_width
		$error("Counter width must be 16 or 32");
	end
	if (NUM_SRC < 2) begin : g_bad_src
		$error("At least two trigger sources are needed");
	end

	// ****************************************
	// Event selection and detection
	// ****************************************
	logic [tpu_pkg::TPU_NUM_EVENTS-1:0] ev_raw;
	logic [tpu_pkg::TPU_NUM_EVENTS-1:0] ev;
	tpu_pkg::tpu_edge_t ev_edge [tpu_pkg::TPU_NUM_EVENTS];

	assign ev_raw[tpu_pkg::TPU_EV_START]   = trig_src_in[start_sel_in];
	assign ev_raw[tpu_pkg::TPU_EV_RELOAD]  = trig_src_in[reload_sel_in];
	assign ev_raw[tpu_pkg::TPU_EV_STOP]    = trig_src_in[stop_sel_in];
	assign ev_raw[tpu_pkg::TPU_EV_COUNT]   = trig_src_in[count_sel_in];
	assign ev_raw[tpu_pkg::TPU_EV_CAPTURE] = trig_src_in[capture_sel_in];
	assign ev_edge[tpu_pkg::TPU_EV_START]   = start_edge_in;
	assign ev_edge[tpu_pkg::TPU_EV_RELOAD]  = reload_edge_in;
	assign ev_edge[tpu_pkg::TPU_EV_STOP]    = stop_edge_in;
	assign ev_edge[tpu_pkg::TPU_EV_COUNT]   = count_edge_in;
	assign ev_edge[tpu_pkg::TPU_EV_CAPTURE] = capture_edge_in;

	for (genvar g = 0; g < tpu_pkg::TPU_NUM_EVENTS; g++) begin : g_ev
		tpu_event_detect u_det (
			.clk_sys_in  (clk_sys_in),
			.resetn_in   (resetn_in),
			.trig_in     (ev_raw[g]),
			.edge_sel_in (ev_edge[g]),
			.event_out   (ev[g])
		);
	end

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [WIDTH-1:0]                  cnt;
		logic [WIDTH-1:0]                  period;
		logic [WIDTH-1:0]                  period_sh;
		logic [WIDTH-1:0]                  compare;
		logic [WIDTH-1:0]                  compare_sh;
		logic [WIDTH-1:0]                  capture;
		logic [tpu_pkg::TPU_MAX_PRESCALE-1:0] pre;
		logic [31:0]                       lfsr;
		logic [tpu_pkg::TPU_DT_WIDTH-1:0]  dt_cnt;
		logic                              running;
		logic                              down;
		logic                              pwm_raw;
		logic                              pwm_main;
		logic                              pwm_comp;
		logic                              qa;
		logic                              qb;
		logic                              unf;
		logic                              ovf;
		logic                              cce;
	} tpu_state_t;

	tpu_state_t state_ff;
	tpu_state_t nxt_state;

	function automatic logic is_pwm(input tpu_pkg::tpu_mode_t m);
		return m == tpu_pkg::TPU_MODE_PWM || m == tpu_pkg::TPU_MODE_PRPWM ||
		       m == tpu_pkg::TPU_MODE_PWMDT;
	endfunction : is_pwm

	logic                                 tick;
	logic [tpu_pkg::TPU_MAX_PRESCALE-1:0] pre_mask;
	logic                                 step;
	logic                                 at_top;
	logic                                 at_zero;
	logic                                 q_move;
	logic                                 q_up;
	logic                                 raw_level;

	always_comb begin
		nxt_state = state_ff;
		nxt_state.unf = 1'b0;
		nxt_state.ovf = 1'b0;
		nxt_state.cce = 1'b0;
		pre_mask = tpu_pkg::TPU_MAX_PRESCALE'((8'h01 << prescale_in) - 8'h01);
		tick = (state_ff.pre & pre_mask) == pre_mask;
		nxt_state.pre = state_ff.running ? state_ff.pre + 1'b1 : '0;
		at_top = state_ff.cnt >= state_ff.period;
		at_zero = state_ff.cnt == '0;
		nxt_state.qa = phase_a_in;
		nxt_state.qb = phase_b_in;
		q_move = (phase_a_in ^ state_ff.qa) ^ (phase_b_in ^ state_ff.qb);
		q_up = phase_a_in ^ state_ff.qb;
		if (mode_in == tpu_pkg::TPU_MODE_QUAD) begin
			step = state_ff.running && q_move;
		end else if (count_edge_in == tpu_pkg::TPU_EDGE_LEVEL) begin
			step = state_ff.running && tick && ev[tpu_pkg::TPU_EV_COUNT];
		end else begin
			step = state_ff.running && ev[tpu_pkg::TPU_EV_COUNT] && tick;
		end
		if (period_wr_in) begin
			nxt_state.period_sh = period_buf_in;
		end
		if (compare_wr_in) begin
			nxt_state.compare_sh = compare_buf_in;
		end
		if (ev[tpu_pkg::TPU_EV_START] && enable_in) begin
			nxt_state.running = 1'b1;
		end
		if (ev[tpu_pkg::TPU_EV_RELOAD] && enable_in) begin
			nxt_state.running = 1'b1;
			nxt_state.period = state_ff.period_sh;
			nxt_state.compare = state_ff.compare_sh;
			nxt_state.cnt = (dir_in == tpu_pkg::TPU_DIR_DOWN) ?
			                state_ff.period_sh : '0;
			nxt_state.down = dir_in == tpu_pkg::TPU_DIR_DOWN;
		end else if (step) begin
			if (mode_in == tpu_pkg::TPU_MODE_QUAD) begin
				nxt_state.cnt = q_up ? state_ff.cnt + 1'b1 : state_ff.cnt - 1'b1;
				nxt_state.ovf = q_up && at_top;
				nxt_state.unf = !q_up && at_zero;
			end else if (!state_ff.down) begin
				if (at_top) begin
					nxt_state.ovf = 1'b1;
					nxt_state.period = state_ff.period_sh;
					nxt_state.compare = state_ff.compare_sh;
					if (dir_in == tpu_pkg::TPU_DIR_UPDN) begin
						nxt_state.down = 1'b1;
						nxt_state.cnt = state_ff.cnt - 1'b1;
					end else begin
						nxt_state.cnt = '0;
					end
				end else begin
					nxt_state.cnt = state_ff.cnt + 1'b1;
				end
			end else begin
				if (at_zero) begin
					nxt_state.unf = 1'b1;
					nxt_state.period = state_ff.period_sh;
					nxt_state.compare = state_ff.compare_sh;
					if (dir_in == tpu_pkg::TPU_DIR_UPDN) begin
						nxt_state.down = 1'b0;
						nxt_state.cnt = state_ff.cnt + 1'b1;
					end else begin
						nxt_state.cnt = state_ff.period_sh;
					end
				end else begin
					nxt_state.cnt = state_ff.cnt - 1'b1;
				end
			end
			if (mode_in == tpu_pkg::TPU_MODE_CMP &&
			    state_ff.cnt == state_ff.compare) begin
				nxt_state.cce = 1'b1;
			end
			nxt_state.lfsr = {state_ff.lfsr[30:0],
			                  state_ff.lfsr[31] ^ state_ff.lfsr[21] ^
			                  state_ff.lfsr[1] ^ state_ff.lfsr[0]};
		end
		if (ev[tpu_pkg::TPU_EV_CAPTURE] && state_ff.running &&
		    mode_in == tpu_pkg::TPU_MODE_CAP) begin
			nxt_state.capture = state_ff.cnt;
			nxt_state.cce = 1'b1;
		end
		if (ev[tpu_pkg::TPU_EV_STOP] || !enable_in) begin
			nxt_state.running = 1'b0;
		end
		// Pseudo-random mode compares against scrambled bits to spread spectrum.
		if (mode_in == tpu_pkg::TPU_MODE_PRPWM) begin
			raw_level = state_ff.lfsr[WIDTH-1:0] < state_ff.compare;
		end else begin
			raw_level = state_ff.cnt < state_ff.compare;
		end
		nxt_state.pwm_raw = raw_level;
		if (mode_in == tpu_pkg::TPU_MODE_PWMDT) begin
			// A level change restarts the gap; both sides stay low meanwhile.
			if (raw_level != state_ff.pwm_raw) begin
				nxt_state.dt_cnt = dead_time_in;
				nxt_state.pwm_main = raw_level && dead_time_in == '0;
				nxt_state.pwm_comp = !raw_level && dead_time_in == '0;
			end else if (state_ff.dt_cnt != '0) begin
				// The last tick releases the waiting side, so the gap is exact.
				if (tick) begin
					nxt_state.dt_cnt = state_ff.dt_cnt - 1'b1;
					nxt_state.pwm_main = raw_level && nxt_state.dt_cnt == '0;
					nxt_state.pwm_comp = !raw_level && nxt_state.dt_cnt == '0;
				end
			end else begin
				nxt_state.pwm_main = raw_level;
				nxt_state.pwm_comp = !raw_level;
			end
		end else begin
			nxt_state.dt_cnt = '0;
			nxt_state.pwm_main = raw_level;
			nxt_state.pwm_comp = !raw_level;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!resetn_in) begin
			state_ff <= '0;
			state_ff.lfsr <= tpu_pkg::TPU_LFSR_SEED;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	logic pwm_active;
	assign pwm_active = is_pwm(mode_in) && state_ff.running;

	assign count_out     = state_ff.cnt;
	assign capture_out   = state_ff.capture;
	assign running_out   = state_ff.running;
	assign underflow_out = state_ff.unf;
	assign overflow_out  = state_ff.ovf;
	assign cc_event_out  = state_ff.cce;
	assign irq_tc_out    = state_ff.ovf | state_ff.unf;
	assign irq_cc_out    = state_ff.cce;
	assign pwm_out   = kill_in ? kill_level_in :
	                   (pwm_active & state_ff.pwm_main);
	assign pwm_n_out = kill_in ? kill_level_in :
	                   (pwm_active & state_ff.pwm_comp);
endmodule : tpu_timer_pwm_unit

/* tpu_timer_pwm_unit_monitor.sv */
// Checker for the timer/counter/PWM unit, bound to its top module.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/10ps
module tpu_timer_pwm_unit_monitor #(
	parameter int WIDTH = 32
) (
	// Clock, reset and configuration
	input wire logic               clk_sys_in,
	input wire logic               resetn_in,
	input wire logic               enable_in,
	input wire tpu_pkg::tpu_mode_t mode_in,
	input wire tpu_pkg::tpu_dir_t  dir_in,
	input wire logic               kill_level_in,
	input wire logic               kill_in,
	// Observed outputs
	input wire logic [WIDTH-1:0]   count_out,
	input wire logic [WIDTH-1:0]   capture_out,
	input wire logic               running_out,
	input wire logic               underflow_out,
	input wire logic               overflow_out,
	input wire logic               cc_event_out,
	input wire logic               irq_tc_out,
	input wire logic               irq_cc_out,
	input wire logic               pwm_out,
	input wire logic               pwm_n_out
);
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!resetn_in);
	chk_kill_forces_out: assert property (
		kill_in |-> pwm_out == kill_level_in && pwm_n_out == kill_level_in)
		else $error("kill did not force both outputs");
	chk_pwm_is_inverse: assert property (
		running_out && !kill_in && mode_in == tpu_pkg::TPU_MODE_PWM &&
		$past(mode_in) == tpu_pkg::TPU_MODE_PWM |-> pwm_n_out != pwm_out)
		else $error("complementary output not inverse");
	chk_dead_no_overlap: assert property (
		mode_in == tpu_pkg::TPU_MODE_PWMDT && !kill_in |->
		!(pwm_out && pwm_n_out)) else $error("both outputs high");
	chk_tc_irq_cause: assert property (
		irq_tc_out == (overflow_out || underflow_out) &&
		(!irq_tc_out || $past(running_out)))
		else $error("terminal count interrupt mismatch");
	chk_cc_irq_cause: assert property (
		irq_cc_out == cc_event_out &&
		(!irq_cc_out || $past(mode_in) == tpu_pkg::TPU_MODE_CMP ||
		 $past(mode_in) == tpu_pkg::TPU_MODE_CAP))
		else $error("cc interrupt mismatch");
	chk_up_wrap_zero: assert property (
		overflow_out && $past(dir_in) == tpu_pkg::TPU_DIR_UP &&
		$past(mode_in) != tpu_pkg::TPU_MODE_QUAD |-> count_out == '0)
		else $error("overflow without wrap to zero");
	chk_stopped_holds: assert property (
		!enable_in && !$past(enable_in) |=> $stable(count_out))
		else $error("count moved while disabled");
	chk_capture_mode: assert property (
		capture_out != $past(capture_out) |->
		$past(mode_in) == tpu_pkg::TPU_MODE_CAP)
		else $error("capture outside capture mode");
endmodule : tpu_timer_pwm_unit_monitor
bind tpu_timer_pwm_unit tpu_timer_pwm_unit_monitor #(.WIDTH(WIDTH)) mon_i (
	.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .enable_in(enable_in),
	.mode_in(mode_in), .dir_in(dir_in), .kill_level_in(kill_level_in),
	.kill_in(kill_in), .count_out(count_out), .capture_out(capture_out),
	.running_out(running_out), .underflow_out(underflow_out),
	.overflow_out(overflow_out), .cc_event_out(cc_event_out),
	.irq_tc_out(irq_tc_out), .irq_cc_out(irq_cc_out), .pwm_out(pwm_out),
	.pwm_n_out(pwm_n_out));

/* tpu_timer_pwm_unit_test.sv */
// Self-checking bench for the 16-bit build of the timer/PWM unit.
// Assumes the checker is bound in and the drive model holds the pins.
`timescale 1ns/10ps
module tpu_timer_pwm_unit_test;
	// ****************************************
	// Signals and ordinary cases
	// ****************************************
	localparam int W = tpu_pkg::TPU_WIDTH_NARROW;
	typedef struct {int pre, per, n, cnt, ovf;} tpu_row_t;
	tpu_row_t rows[9] = '{'{0, 5, 4, 4, 0}, '{0, 2, 4, 1, 1},
		'{1, 3, 8, 0, 1}, '{2, 7, 12, 3, 0}, '{3, 1, 16, 0, 1},
		'{4, 9, 32, 2, 0}, '{5, 9, 64, 2, 0}, '{6, 9, 128, 2, 0},
		'{7, 9, 256, 2, 0}};
	logic clk_sys_in = 0, resetn_in = 0, enable_in = 0, kill_in = 0;
	logic kill_lvl = 0, period_wr = 0, compare_wr = 0, step = 0, fwd = 0;
	logic pha, phb, running, unf, ovf, cc, irq_tc, irq_cc, pwm, pwm_n;
	logic [2:0] prescale = 0;
	logic [2:0] sel[5] = '{3'h3, 3'h0, 3'h2, 3'h1, 3'h4};
	logic [7:0] dead_time = 0, trig = 0;
	logic [W-1:0] per_buf = 0, cmp_buf = 0, count, capture;
	tpu_pkg::tpu_mode_t mode = tpu_pkg::TPU_MODE_CMP;
	tpu_pkg::tpu_dir_t dir = tpu_pkg::TPU_DIR_UP;
	tpu_pkg::tpu_edge_t edg[5];
	int errors = 0, checks = 0, ovf_n, unf_n, cc_n, ovl, hi, hn, base;
	tpu_timer_pwm_unit #(.WIDTH(W), .NUM_SRC(8)) tpu_timer_pwm_unit_i (
		.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
		.enable_in(enable_in), .mode_in(mode), .dir_in(dir),
		.prescale_in(prescale), .dead_time_in(dead_time),
		.kill_level_in(kill_lvl), .period_buf_in(per_buf),
		.period_wr_in(period_wr), .compare_buf_in(cmp_buf),
		.compare_wr_in(compare_wr), .trig_src_in(trig),
		.start_sel_in(sel[0]), .reload_sel_in(sel[1]), .stop_sel_in(sel[2]),
		.count_sel_in(sel[3]), .capture_sel_in(sel[4]),
		.start_edge_in(edg[0]), .reload_edge_in(edg[1]),
		.stop_edge_in(edg[2]), .count_edge_in(edg[3]),
		.capture_edge_in(edg[4]), .kill_in(kill_in), .phase_a_in(pha),
		.phase_b_in(phb), .count_out(count), .capture_out(capture),
		.running_out(running), .underflow_out(unf), .overflow_out(ovf),
		.cc_event_out(cc), .irq_tc_out(irq_tc), .irq_cc_out(irq_cc),
		.pwm_out(pwm), .pwm_n_out(pwm_n));
	tpu_drive_model tpu_drive_model_i (.clk_sys_in(clk_sys_in),
		.step_in(step), .fwd_in(fwd), .pwm_in(pwm), .pwm_n_in(pwm_n),
		.phase_a_out(pha), .phase_b_out(phb), .overlap_out(ovl));
	initial forever #20 clk_sys_in = ~clk_sys_in;
	// Pulses stand one cycle, so each is counted exactly once here.
	always @(posedge clk_sys_in) begin
		ovf_n += ovf;
		unf_n += unf;
		cc_n += cc;
	end
	// ****************************************
	// Tasks
	// ****************************************
	task automatic tick(int n);
		repeat (n) @(posedge clk_sys_in);
		#1;
	endtask : tick
	task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s expected %0h seen %0h", name, exp, seen);
		end
	endtask : chk
	task automatic pulse(logic [7:0] m);
		trig = trig | m;
		tick(1);
		trig = trig & ~m;
		tick(2);
	endtask : pulse
	task automatic run(int n);
		trig[1] = 1'h1;
		tick(n);
		trig[1] = 1'h0;
		tick(2);
	endtask : run
	task automatic qstep(logic f, int n);
		fwd = f;
		step = 1'h1;
		tick(n);
		step = 1'h0;
		tick(3);
	endtask : qstep
	task automatic setup(tpu_pkg::tpu_mode_t m, int per, int cmp);
		mode = m;
		enable_in = 1'h1;
		per_buf = W'(per);
		cmp_buf = W'(cmp);
		period_wr = 1'h1;
		compare_wr = 1'h1;
		tick(1);
		period_wr = 1'h0;
		compare_wr = 1'h0;
		pulse(8'h01);
		ovf_n = 0;
		unf_n = 0;
		cc_n = 0;
	endtask : setup
	task automatic report_and_stop();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (6000) @(posedge clk_sys_in);
		errors++;
		report_and_stop();
	end
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		edg = '{default: tpu_pkg::TPU_EDGE_RISE};
		edg[3] = tpu_pkg::TPU_EDGE_LEVEL;
		tick(16);
		resetn_in = 1'h1;
		foreach (rows[i]) begin
			prescale = rows[i].pre[2:0];
			setup(tpu_pkg::TPU_MODE_CMP, rows[i].per, 9);
			run(rows[i].n);
			chk("count", count, rows[i].cnt);
			chk("overflows", ovf_n, rows[i].ovf);
		end
		$display("table done");
		prescale = 3'h0;
		setup(tpu_pkg::TPU_MODE_CMP, 5, 2);
		run(2);
		per_buf = W'(1);
		period_wr = 1'h1;
		tick(1);
		period_wr = 1'h0;
		run(3);
		chk("old period kept", count, 5);
		run(3);
		chk("new period used", count, 0);
		chk("shadow overflows", ovf_n, 2);
		chk("compare events", cc_n, 1);
		$display("shadow and compare done");
		setup(tpu_pkg::TPU_MODE_CMP, 9, 9);
		for (int e = 0; e < 4; e++) begin
			edg[1] = tpu_pkg::tpu_edge_t'(e);
			run(3);
			trig[0] = 1'h1;
			tick(2);
			chk("reload after rise", count, (e == 1) ? 5 : 0);
			run(2);
			trig[0] = 1'h0;
			tick(2);
			chk("reload after fall", count, (e == 0) ? 2 : 0);
		end
		edg[3] = tpu_pkg::TPU_EDGE_RISE;
		run(4);
		chk("count on edge", count, 1);
		edg[3] = tpu_pkg::TPU_EDGE_LEVEL;
		edg[1] = tpu_pkg::TPU_EDGE_RISE;
		$display("edges done");
		setup(tpu_pkg::TPU_MODE_CAP, 9, 9);
		run(3);
		pulse(8'h10);
		chk("captured", capture, 3);
		chk("capture events", cc_n, 1);
		mode = tpu_pkg::TPU_MODE_CMP;
		run(1);
		pulse(8'h10);
		chk("capture refused", capture, 3);
		setup(tpu_pkg::TPU_MODE_QUAD, 100, 9);
		qstep(1'h1, 4);
		chk("quad forward", count, 4);
		qstep(1'h0, 2);
		chk("quad reverse", count, 2);
		$display("capture and quadrature done");
		setup(tpu_pkg::TPU_MODE_PWM, 3, 2);
		dead_time = 8'h01;
		trig[1] = 1'h1;
		base = ovl;
		for (int m = 3; m < 6; m++) begin
			mode = tpu_pkg::tpu_mode_t'(m);
			tick(6);
			hi = 0;
			hn = 0;
			repeat (8) begin
				hi += pwm;
				hn += pwm_n;
				tick(1);
			end
			if (m == 3) begin
				chk("pwm high", hi, 4);
				chk("pwm low", hn, 4);
			end else if (m == 4) begin
				chk("prpwm pair", hi + hn, 8);
			end else begin
				chk("dead high", hi, 2);
				chk("dead low", hn, 2);
			end
		end
		chk("overlap", ovl - base, 0);
		kill_in = 1'h1;
		for (int k = 0; k < 2; k++) begin
			kill_lvl = k[0];
			tick(1);
			chk("kill main", pwm, k);
			chk("kill inverse", pwm_n, k);
		end
		kill_in = 1'h0;
		trig[1] = 1'h0;
		$display("pwm and kill done");
		dir = tpu_pkg::TPU_DIR_DOWN;
		setup(tpu_pkg::TPU_MODE_CMP, 3, 9);
		run(4);
		chk("underflows", unf_n, 1);
		chk("no overflow", ovf_n, 0);
		dir = tpu_pkg::TPU_DIR_UPDN;
		setup(tpu_pkg::TPU_MODE_CMP, 3, 9);
		run(8);
		chk("updown count", count, 2);
		chk("updown turns", ovf_n + unf_n, 2);
		dir = tpu_pkg::TPU_DIR_UP;
		setup(tpu_pkg::TPU_MODE_CMP, 9, 9);
		run(2);
		enable_in = 1'h0;
		tick(1);
		run(2);
		pulse(8'h01);
		chk("disabled hold", count, 2);
		enable_in = 1'h1;
		pulse(8'h08);
		pulse(8'h04);
		chk("stopped", running, 0);
		run(2);
		chk("stopped hold", count, 2);
		pulse(8'h08);
		chk("started", running, 1);
		pulse(8'h0C);
		chk("stop wins", running, 0);
		$display("direction and events done");
		pulse(8'h08);
		resetn_in = 1'h0;
		tick(3);
		chk("reset count", count, 0);
		chk("reset capture", capture, 0);
		chk("reset running", running, 0);
		resetn_in = 1'h1;
		tick(1);
		$display("reset done");
		report_and_stop();
	end
endmodule : tpu_timer_pwm_unit_test
